// >>> hw/rdblk_pkg.sv
// Purpose: Shared constants for the read block cache sequencer
// Assumes: One system clock; a phase signal toggling every whole cycle outside idle is derived inside the sequencer
// Notes:   Encodings of request, acknowledge and bridge command lines are plain defaults
package rdblk_pkg;
	localparam logic [2:0] CREQ_IDLE      = 3'h0;
	localparam logic [2:0] CREQ_READ_BLK  = 3'h2;
	localparam logic [2:0] DACK_IDLE      = 3'h0;
	localparam logic [2:0] DACK_OK        = 3'h5;
	localparam logic [2:0] DACK_NONCACHE  = 3'h1;
	localparam logic [2:0] CACK_IDLE      = 3'h0;
	localparam logic [2:0] CACK_OK        = 3'h4;
	localparam logic [2:0] IO_BRIDGE_COMMAND_IDLE     = 3'h0;
	localparam logic [2:0] IO_BRIDGE_COMMAND_DACK_REQ = 3'h1;
	localparam logic [2:0] IO_BRIDGE_COMMAND_CACK_REQ = 3'h2;
	localparam int         ADR_HI         = 33;
	localparam int         ADR_LO         = 5;
	localparam int         WMASK_ISTREAM  = 2;
	localparam logic [1:0] SPACE_CACHE    = 2'h0;
	localparam logic [1:0] SPACE_NONCACHE = 2'h1;
	localparam logic [1:0] SPACE_IO       = 2'h2;
	localparam logic [33:0] IO_SPACE_BASE = 34'h200000000;
	localparam logic [33:0] NONCACHE_BASE = 34'h100000000;
endpackage : rdblk_pkg

// >>> hw/rdblk_seq.sv
// Purpose: Sequencer for processor read block transactions on the system bus
// Assumes: Fill data readiness and victim status come from same-clock logic;
//          the tag valid pin comes from the cache SRAMs and is synchronised here; tag dirty is not used
// Notes:   Phase two signal generated by a toggle each cycle, so high on alternate whole cycles; cleared while idle
// Notes on behaviour
// [R01] Idle: all cache controls off except early output enable, which stays on.
// [R02] Read request with early enable on asserts cache data and tag enables.
// [R03] Cycle two decodes address bits 33:5 into cacheable, noncacheable or I/O.
// [R04] Victim read: low then high latch enables give one-cycle address bit 4 pulse.
// [R05] After second victim octaword, early and data output enables drop.
// [R06] After victim read, drive new tag marked valid and clean.
// [R07] Wrapped read asserts address bit 4 first in cycle four.
// [R08] Instruction read with previously valid line raises data cache invalidate.
// [R09] Stall until fill ready, then drive, acknowledge OK, write tag and data.
// [R10] During first fill write, address bit 4 switches for the second octaword: high, or low if wrapped.
// [R11] Cycle six writes second octaword, acknowledges OK, then drops bit 4.
// [R12] Cycle acknowledge no earlier than cycle seven; controls return to idle.
// [R13] After completion, early enable returns next cycle if processor won bus.
// [R14] Clean or invalid tag discards cache data, same sequence as victim case.
// [R15] Noncacheable read drops early output enable in cycle two.
// [R16] Noncacheable read asserts tag output enable in cycle three.
// [R17] Noncacheable: one octaword acknowledged noncacheable, no invalidate, ack later.
// [R18] Cache disabled: as noncacheable but full hexaword acknowledged OK.
// [R19] I/O read drops early enable and asserts tag output enable in cycle two.
// [R20] Bridge loads read buffer; only final transfer requests data acknowledge.
// [R21] Bridge ack request gives noncacheable data ack; next request ends cycle.
// [R22] Ignore-tag set: fill from memory as clean block regardless of tag.
`timescale 1ns/10ps
module rdblk_seq (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_n,
	input  wire logic [2:0]  i_cpu_cycle_request,
	input  wire logic [33:0] i_system_address,
	input  wire logic [7:0]  i_cpu_write_mask,
	input  wire logic        i_wrapped_read,
	input  wire logic        i_tag_valid,
	input  wire logic        i_tag_dirty,
	input  wire logic        i_cache_enable,
	input  wire logic        i_ignore_tag_control,
	input  wire logic        i_fill_ready,
	input  wire logic        i_cpu_won_arb,
	input  wire logic [2:0]  i_io_bridge_command,
	output logic             o_early_cache_output_enable,
	output logic             o_cache_data_output_enable,
	output logic             o_cache_tag_output_enable,
	output logic             o_tag_output_enable_ctl,
	output logic             o_cache_data_out_enable_ctl,
	output logic             o_low_addr_latch_enable,
	output logic             o_high_addr_latch_enable,
	output logic             o_cache_data_address4,
	output logic             o_tag_write_strobe,
	output logic             o_tag_control_write_enable,
	output logic             o_tag_address_write_enable,
	output logic             o_cache_data_write_enable_ctl,
	output logic             o_cache_data_write_enable,
	output logic             o_new_tag_valid,
	output logic             o_new_tag_dirty,
	output logic             o_drive_system_data,
	output logic             o_dcache_invalidate_request,
	output logic [2:0]       o_data_read_acknowledge,
	output logic [2:0]       o_cycle_acknowledge,
	output logic             o_phase_two_falling_edge
);
	typedef enum logic [3:0] {
		ST_IDLE, ST_DECODE, ST_VIC2, ST_VIC3, ST_FILLWAIT, ST_FILL2, ST_CACK,
		ST_NC_TAG, ST_NC_DATA, ST_NC_DATA2, ST_IO_WAIT, ST_IO_CACK, ST_TURN
	} seq_state_type;

	typedef struct packed {
		seq_state_type st;
		logic [1:0]    space;
		logic          was_valid;
		logic          istream;
		logic          wrap;
		logic          hexa;
		logic          phase;
		logic          sync0;
		logic          sync1;
		logic          early_oe;
		logic          data_oe_ctl;
		logic          tag_oe_ctl;
		logic          ale_lo;
		logic          ale_hi;
		logic          a4;
		logic          tag_we;
		logic          data_we;
		logic          new_valid;
		logic          drive;
		logic          inv;
		logic [2:0]    dack;
		logic [2:0]    cack;
	} seq_type;

	seq_type s_r;
	seq_type s_nxt;

	function automatic logic [1:0] classify(input logic [33:0] adr);
		logic [28:0] blk;
		blk = adr[rdblk_pkg::ADR_HI:rdblk_pkg::ADR_LO];
		if (blk >= rdblk_pkg::IO_SPACE_BASE[rdblk_pkg::ADR_HI:rdblk_pkg::ADR_LO])
			return rdblk_pkg::SPACE_IO;
		else if (blk >= rdblk_pkg::NONCACHE_BASE[rdblk_pkg::ADR_HI:rdblk_pkg::ADR_LO])
			return rdblk_pkg::SPACE_NONCACHE;
		return rdblk_pkg::SPACE_CACHE;
	endfunction : classify

	always_comb begin
		s_nxt = s_r;
		s_nxt.sync0 = i_tag_valid;
		s_nxt.sync1 = s_r.sync0;
		s_nxt.phase = ~s_r.phase;
		s_nxt.dack = rdblk_pkg::DACK_IDLE;
		s_nxt.cack = rdblk_pkg::CACK_IDLE;
		s_nxt.tag_we = 1'b0;
		s_nxt.data_we = 1'b0;
		s_nxt.inv = 1'b0;
		s_nxt.ale_lo = 1'b0;
		s_nxt.ale_hi = 1'b0;
		case (s_r.st)
			ST_IDLE: begin
				s_nxt.early_oe = 1'b1; // R01
				s_nxt.phase = 1'b0;
				if (i_cpu_cycle_request == rdblk_pkg::CREQ_READ_BLK) begin
					s_nxt.st = ST_DECODE; // R02
					s_nxt.istream = ~i_cpu_write_mask[rdblk_pkg::WMASK_ISTREAM];
					s_nxt.wrap = i_wrapped_read;
				end
			end
			ST_DECODE: begin
				s_nxt.space = classify(i_system_address); // R03
				s_nxt.was_valid = s_r.sync1 & ~i_ignore_tag_control; // R22
				if (classify(i_system_address) == rdblk_pkg::SPACE_IO) begin
					s_nxt.early_oe = 1'b0; // R19
					s_nxt.tag_oe_ctl = 1'b1; // R19
					s_nxt.st = ST_IO_WAIT;
				end else if (classify(i_system_address) == rdblk_pkg::SPACE_NONCACHE
						|| !i_cache_enable) begin
					s_nxt.early_oe = 1'b0; // R15
					s_nxt.hexa = i_cache_enable ? 1'b0 : 1'b1; // R18
					s_nxt.st = ST_NC_TAG;
				end else begin
					// Clean or invalid victim data is simply ignored
					s_nxt.ale_lo = 1'b1; // R04 R14
					s_nxt.data_oe_ctl = 1'b1; // R04
					s_nxt.st = ST_VIC2;
				end
			end
			ST_VIC2: begin
				s_nxt.ale_hi = 1'b1; // R04
				s_nxt.early_oe = 1'b0; // R05
				s_nxt.data_oe_ctl = 1'b0; // R05
				s_nxt.st = ST_VIC3;
			end
			ST_VIC3: begin
				s_nxt.new_valid = 1'b1; // R06
				s_nxt.a4 = s_r.wrap; // R07
				s_nxt.inv = s_r.istream & s_r.was_valid; // R08
				s_nxt.st = ST_FILLWAIT;
			end
			ST_FILLWAIT: begin
				if (i_fill_ready) begin
					s_nxt.drive = 1'b1; // R09
					s_nxt.dack = rdblk_pkg::DACK_OK; // R09
					s_nxt.tag_we = 1'b1; // R09 R22
					s_nxt.data_we = 1'b1; // R09
					s_nxt.a4 = ~s_r.wrap; // R10
					s_nxt.st = ST_FILL2;
				end
			end
			ST_FILL2: begin
				s_nxt.data_we = 1'b1; // R11
				s_nxt.dack = rdblk_pkg::DACK_OK; // R11
				s_nxt.st = ST_CACK;
			end
			ST_CACK: begin
				s_nxt.a4 = 1'b0; // R11
				s_nxt.cack = rdblk_pkg::CACK_OK; // R12
				s_nxt.drive = 1'b0; // R12
				s_nxt.new_valid = 1'b0;
				s_nxt.tag_oe_ctl = 1'b0;
				s_nxt.st = ST_TURN;
			end
			ST_NC_TAG: begin
				s_nxt.tag_oe_ctl = 1'b1; // R16
				s_nxt.st = ST_NC_DATA;
			end
			ST_NC_DATA: begin
				if (i_fill_ready) begin
					s_nxt.drive = 1'b1;
					s_nxt.dack = s_r.hexa ? rdblk_pkg::DACK_OK
						: rdblk_pkg::DACK_NONCACHE; // R17 R18
					s_nxt.st = s_r.hexa ? ST_NC_DATA2 : ST_CACK;
				end
			end
			ST_NC_DATA2: begin
				s_nxt.dack = rdblk_pkg::DACK_OK; // R18
				s_nxt.st = ST_CACK;
			end
			ST_IO_WAIT: begin
				if (i_io_bridge_command == rdblk_pkg::IO_BRIDGE_COMMAND_DACK_REQ) begin
					s_nxt.drive = 1'b1; // R20 R21
					s_nxt.dack = rdblk_pkg::DACK_NONCACHE; // R21
					s_nxt.st = ST_IO_CACK;
				end
			end
			ST_IO_CACK: begin
				if (i_io_bridge_command == rdblk_pkg::IO_BRIDGE_COMMAND_CACK_REQ) begin
					s_nxt.drive = 1'b0; // R21
					s_nxt.cack = rdblk_pkg::CACK_OK; // R21
					s_nxt.tag_oe_ctl = 1'b0; // R21
					s_nxt.st = ST_TURN;
				end
			end
			ST_TURN: begin
				// Bus turnaround: held here for as long as the bridge wins, until the processor wins arbitration
				if (i_cpu_won_arb) begin
					s_nxt.early_oe = 1'b1; // R13
					s_nxt.st = ST_IDLE;
				end
			end
			default: begin
				s_nxt.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_r <= '0;
			s_r.st <= ST_IDLE;
			s_r.early_oe <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_early_cache_output_enable   = s_r.early_oe;
	assign o_cache_data_output_enable    = s_r.early_oe | s_r.data_oe_ctl;
	assign o_cache_tag_output_enable     = s_r.early_oe | s_r.tag_oe_ctl;
	assign o_tag_output_enable_ctl       = s_r.tag_oe_ctl;
	assign o_cache_data_out_enable_ctl   = s_r.data_oe_ctl;
	assign o_low_addr_latch_enable       = s_r.ale_lo;
	assign o_high_addr_latch_enable      = s_r.ale_hi;
	assign o_cache_data_address4         = s_r.a4 | s_r.ale_hi;
	assign o_tag_write_strobe            = s_r.tag_we;
	assign o_tag_control_write_enable    = s_r.tag_we;
	assign o_tag_address_write_enable    = s_r.tag_we;
	assign o_cache_data_write_enable_ctl = s_r.data_we;
	assign o_cache_data_write_enable     = s_r.data_we;
	assign o_new_tag_valid               = s_r.new_valid;
	assign o_new_tag_dirty               = 1'b0;
	assign o_drive_system_data           = s_r.drive;
	assign o_dcache_invalidate_request   = s_r.inv;
	assign o_data_read_acknowledge       = s_r.dack;
	assign o_cycle_acknowledge           = s_r.cack;
	assign o_phase_two_falling_edge      = s_r.phase;

	a_idle_early_oe: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		s_r.st == ST_IDLE |-> o_early_cache_output_enable && !o_tag_write_strobe)
		else $error("early enable off while idle"); // R01
	a_read_enables: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		s_r.st == ST_DECODE |-> o_cache_data_output_enable && o_cache_tag_output_enable)
		else $error("enables missing on request"); // R02
	sequence victim_start;
		o_low_addr_latch_enable ##1 o_high_addr_latch_enable;
	endsequence
	a_victim_latch: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		$rose(o_low_addr_latch_enable) |-> victim_start ##1 !o_early_cache_output_enable)
		else $error("latch sequence wrong"); // R04
	a_nc_tag_oe: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		s_r.st == ST_NC_TAG |-> ##1 o_tag_output_enable_ctl)
		else $error("tag enable missing"); // R16
	a_nc_no_inv: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		o_data_read_acknowledge == rdblk_pkg::DACK_NONCACHE |-> !o_dcache_invalidate_request)
		else $error("invalidate on noncacheable"); // R17
	a_fill_write: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		o_tag_write_strobe |-> o_cache_data_write_enable ##1 o_cache_data_write_enable
			##1 o_cycle_acknowledge == rdblk_pkg::CACK_OK)
		else $error("fill write sequence wrong"); // R09
	a_cack_late: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		$rose(o_low_addr_latch_enable) |-> ##1 o_cycle_acknowledge == rdblk_pkg::CACK_IDLE
			[*4])
		else $error("cycle ack too early"); // R12
	a_io_end: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		o_cycle_acknowledge == rdblk_pkg::CACK_OK && $past(s_r.st) == ST_IO_CACK
			|-> !o_tag_output_enable_ctl && !o_drive_system_data)
		else $error("io end controls wrong"); // R21
endmodule : rdblk_seq

// >>> verif/far_end_model.sv
// Purpose: Far side of the sequencer: memory fill timing and I/O bridge
// Assumes: Updated by nonblocking assignment on the rising edge, so no race with the bench
// Notes:   Ready stays a level; bridge requests last one cycle each
`timescale 1ns/10ps
module far_end_model (
	input  wire logic       i_core_clk,
	input  wire logic       i_go,
	input  wire logic       i_io,
	input  wire logic [7:0] i_stall,
	output logic            o_fill_ready,
	output logic [2:0]      o_io_bridge_command
);
	logic [7:0] cnt_r;
	initial begin
		cnt_r = 8'h00;
		o_fill_ready = 1'b0;
		o_io_bridge_command = rdblk_pkg::IO_BRIDGE_COMMAND_IDLE;
	end
	always @(posedge i_core_clk) begin
		cnt_r <= i_go ? cnt_r + 8'h01 : 8'h00;
		o_fill_ready <= i_go && !i_io && (cnt_r >= 8'h02 + i_stall);
		// Only the last transfer asks for the data ack
		if (i_go && i_io && cnt_r == 8'h04 + i_stall)
			o_io_bridge_command <= rdblk_pkg::IO_BRIDGE_COMMAND_DACK_REQ;
		else if (i_go && i_io && cnt_r == 8'h05 + i_stall)
			o_io_bridge_command <= rdblk_pkg::IO_BRIDGE_COMMAND_CACK_REQ;
		else
			o_io_bridge_command <= rdblk_pkg::IO_BRIDGE_COMMAND_IDLE;
	end
endmodule : far_end_model

// >>> verif/test_rdblk_seq.sv
// Purpose: Self-checking bench for the read block sequencer
// Assumes: Inputs change on the falling edge; outputs sampled there too
// Notes:   Cycle n counts edges since the request was taken
`timescale 1ns/10ps
module test_rdblk_seq;
	logic        clk = 1'b0, rst_n = 1'b0, go = 1'b0, io = 1'b0;
	logic [2:0]  creq = rdblk_pkg::CREQ_IDLE, io_bridge_command, dack, cack;
	logic [33:0] adr = 34'h0;
	logic [7:0]  wm = 8'h00, stall = 8'h00;
	logic        wrap = 1'b0, tval = 1'b0, tdirty = 1'b0, cen = 1'b1, ign = 1'b0;
	logic        fill, won = 1'b1, early, inv, twe, dwe;
	int          error_cnt = 0, checked = 0, cyc = 0, c0;
	int          r_ok, r_nc, r_inv, r_d1, r_c, r_we, r_twe;
	always #5 clk = ~clk;
	rdblk_seq dut_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_cpu_cycle_request(creq),
		.i_system_address(adr), .i_cpu_write_mask(wm), .i_wrapped_read(wrap),
		.i_tag_valid(tval), .i_tag_dirty(tdirty), .i_cache_enable(cen),
		.i_ignore_tag_control(ign), .i_fill_ready(fill), .i_cpu_won_arb(won),
		.i_io_bridge_command(io_bridge_command), .o_early_cache_output_enable(early),
		.o_cache_data_output_enable(), .o_cache_tag_output_enable(),
		.o_tag_output_enable_ctl(), .o_cache_data_out_enable_ctl(),
		.o_low_addr_latch_enable(), .o_high_addr_latch_enable(),
		.o_cache_data_address4(), .o_tag_write_strobe(twe),
		.o_tag_control_write_enable(), .o_tag_address_write_enable(),
		.o_cache_data_write_enable_ctl(), .o_cache_data_write_enable(dwe),
		.o_new_tag_valid(), .o_new_tag_dirty(), .o_drive_system_data(),
		.o_dcache_invalidate_request(inv), .o_data_read_acknowledge(dack),
		.o_cycle_acknowledge(cack), .o_phase_two_falling_edge());
	far_end_model far_u (.i_core_clk(clk), .i_go(go), .i_io(io), .i_stall(stall),
		.o_fill_ready(fill), .o_io_bridge_command(io_bridge_command));
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %0h, seen %0h", name, exp, seen);
		end
	endtask : check
	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : report_and_stop
	// One read block; tallies what comes back until the cycle ack
	task automatic run_read(input logic [33:0] a, input logic isio, input logic [7:0] st);
		int n;
		{r_ok, r_nc, r_inv, r_we, r_twe} = '0;
		r_d1 = -1;
		r_c = -1;
		adr = a;
		io = isio;
		stall = st;
		repeat (3) @(negedge clk);
		creq = rdblk_pkg::CREQ_READ_BLK;
		go = 1'b1;
		@(negedge clk);
		creq = rdblk_pkg::CREQ_IDLE;
		for (n = 1; n < 60 && r_c < 0; n++) begin
			r_ok += (dack === rdblk_pkg::DACK_OK);
			r_nc += (dack === rdblk_pkg::DACK_NONCACHE);
			r_inv += (inv === 1'b1);
			r_we += (dwe === 1'b1);
			r_twe += (twe === 1'b1);
			if (r_d1 < 0 && dack !== rdblk_pkg::DACK_IDLE) r_d1 = n;
			if (cack === rdblk_pkg::CACK_OK) r_c = n;
			if (r_c < 0) @(negedge clk);
		end
		go = 1'b0;
		repeat (2) @(negedge clk);
		check("early enable after ack", early, 1'b1);
	endtask : run_read
	task automatic t_idle();
		check("idle early enable", early, 1'b1);
		check("idle data write", dwe, 1'b0);
		check("idle cycle ack", cack, rdblk_pkg::CACK_IDLE);
	endtask : t_idle
	task automatic t_victim();
		{tval, tdirty, wrap, wm} = {3'b111, 8'h00};
		run_read(34'h000000040, 1'b0, 8'h00);
		c0 = r_c;
		check("victim ok acks", r_ok, 2);
		check("victim invalidate", r_inv, 1);
		check("victim data writes", r_we, 2);
		check("victim tag writes", r_twe, 1);
		check("victim ack not early", r_c >= 7, 1);
	endtask : t_victim
	task automatic t_stall();
		{tdirty, wrap, wm} = {2'b00, 8'h04};
		run_read(34'h000001000, 1'b0, 8'h05);
		check("dstream invalidate", r_inv, 0);
		check("stalled ack later", r_c > c0, 1);
		check("clean ok acks", r_ok, 2);
	endtask : t_stall
	task automatic t_noncache();
		run_read(rdblk_pkg::NONCACHE_BASE, 1'b0, 8'h00);
		check("noncache acks", r_nc, 1);
		check("noncache ok", r_ok, 0);
		check("noncache invalidate", r_inv, 0);
		check("noncache ack spacing", r_c - r_d1, 1);
	endtask : t_noncache
	task automatic t_disabled();
		cen = 1'b0;
		run_read(34'h000000080, 1'b0, 8'h00);
		check("disabled ok acks", r_ok, 2);
		check("disabled invalidate", r_inv, 0);
		cen = 1'b1;
	endtask : t_disabled
	task automatic t_io();
		run_read(rdblk_pkg::IO_SPACE_BASE, 1'b1, 8'h02);
		check("io noncache ack", r_nc, 1);
		check("io ack spacing", r_c - r_d1, 1);
	endtask : t_io
	task automatic t_igntag();
		{ign, tval, wm} = {2'b11, 8'h00};
		run_read(34'h000000100, 1'b0, 8'h00);
		check("ignore tag ok acks", r_ok, 2);
		check("ignore tag invalidate", r_inv, 0);
		ign = 1'b0;
	endtask : t_igntag
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	initial begin
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		t_idle();
		t_victim();
		t_stall();
		t_noncache();
		t_disabled();
		t_io();
		t_igntag();
		report_and_stop();
	end
endmodule : test_rdblk_seq
